//--- rtl/adc_conversion_timing.sv
// Converter slot sequencer, timing and register file
//
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/10ps
`include "adc_conv_defs.svh"
module adc_conversion_timing #(
    parameter int SLOTS = 4,
    parameter int SW    = 2
) (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Wishbone slave
    input  wire adc_conv_pkg::wb_req_t  wb_i,
    output logic [31:0]                 wb_dat_o,
    output logic                        wb_ack_o,
    // Converter core
    output logic                        sample_o,
    output logic                        hold_o,
    output logic [SW-1:0]               slot_o,
    input  wire logic [11:0]            core_data_i,
    // Interrupt
    output logic                        irq_o
);
    localparam int HOLD_CYC = (`HOLD_LEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

    adc_conv_pkg::seq_state_t state_reg;
    logic [8:0]      acq_window_count [SLOTS];
    logic [11:0]     conversion_result_n [SLOTS];
    logic [SLOTS-1:0] pend_reg;
    logic [SW-1:0]   rr_reg;
    logic [SW-1:0]   cur_reg;
    logic [SW-1:0]   lat_slot_reg;
    logic [8:0]      cnt_reg;
    logic [6:0]      eoc_cnt_reg;
    logic [6:0]      lat_cnt_reg;
    logic            lat_busy_reg;
    logic [3:0]      converter_clock_divider;
    logic            flag_late_position;
    logic [SW-1:0]   done_flag_select;
    logic [1:0]      status_reg;
    logic [1:0]      mask_reg;
    logic            early_reg;
    logic [6:0]      early_cnt_reg;
    logic [SW-1:0]   early_slot_reg;

    // Late flag timer and next values
    logic            late_reg;
    logic [6:0]      late_cnt_reg;
    logic [SW-1:0]   late_slot_reg;
    logic [SLOTS-1:0] pend_next;
    logic [1:0]      status_next;
    logic [31:0]     rd_data_next;

    // Interval after the window per converter_clock_divider
    function automatic logic [6:0] eoc_len(input logic [3:0] d);
        eoc_len = (d == 4'h0) ? `EOC_FIRST : 7'(`EOC_BASE + `EOC_STEP * (d - 4'h2) + 7'h0A);
    endfunction : eoc_len
    // Latch delay per converter_clock_divider
    function automatic logic [6:0] lat_len(input logic [3:0] d);
        unique case (d)
            4'h0: lat_len = 7'h0D;
            4'h2: lat_len = 7'h17;
            4'h3: lat_len = 7'h1C;
            4'h4: lat_len = 7'h22;
            4'h5: lat_len = 7'h27;
            4'h6: lat_len = 7'h2C;
            4'h7: lat_len = 7'h31;
            4'h8: lat_len = 7'h37;
            4'h9: lat_len = 7'h3C;
            4'hA: lat_len = 7'h41;
            4'hB: lat_len = 7'h46;
            4'hC: lat_len = 7'h4C;
            4'hD: lat_len = 7'h51;
            4'hE: lat_len = 7'h56;
            4'hF: lat_len = 7'h5B;
            default: lat_len = 7'h0D;
        endcase
    endfunction : lat_len
    // Round-robin pick from pointer
    function automatic logic [SW-1:0] rr_pick(input logic [SLOTS-1:0] p,
                                              input logic [SW-1:0] ptr);
        logic [SW-1:0] idx;
        rr_pick = ptr;
        for (int k = SLOTS - 1; k >= 0; k--) begin
            idx = SW'((int'(ptr) + k) % SLOTS);
            if (p[idx]) begin
                rr_pick = idx;
            end
        end
    endfunction : rr_pick

    // Acquisition count register decode
    function automatic logic acq_hit(input logic [7:0] a, input int i);
        acq_hit = (a == 8'(`ADDR_ACQ_BASE + 4 * i));
    endfunction : acq_hit

    // Result register decode
    function automatic logic res_hit(input logic [7:0] a, input int i);
        res_hit = (a == 8'(`ADDR_RES_BASE + 4 * i));
    endfunction : res_hit

    wire logic bus_req = wb_i.cyc && wb_i.stb && !wb_ack_o;
    wire logic wr      = bus_req && wb_i.we && wb_i.sel[0];
    wire logic rd      = bus_req && !wb_i.we;
    wire logic win_end = (state_reg == adc_conv_pkg::ST_SAMPLE) && (cnt_reg == 9'h000);
    wire logic lat_fire = lat_busy_reg && (lat_cnt_reg == 7'h01);
    wire logic early_fire = early_reg && (early_cnt_reg == 7'h01);

    // Late flag fires at its interval end
    wire logic late_fire = late_reg && (late_cnt_reg == 7'h01);
    logic [SLOTS-1:0] trig_set;
    always_comb begin
        trig_set = '0;
        if (wr && wb_i.adr == `ADDR_TRIG) begin
            trig_set = wb_i.dat[SLOTS-1:0];
        end
    end

    // Slot chosen for the next window and whether it may start
    logic [SW-1:0] start_slot;
    logic          start_ok;
    always_comb begin
        start_slot = rr_pick(pend_reg, rr_reg);
        start_ok   = (state_reg == adc_conv_pkg::ST_IDLE) && (pend_reg != '0)
                   && (converter_clock_divider != 4'h1);
    end

    // Pending slots: triggers in, started slot out
    always_comb begin
        pend_next = pend_reg | trig_set;
        if (start_ok) begin
            pend_next = pend_next & ~(SLOTS'(1) << start_slot);
        end
    end

    // Sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg   <= adc_conv_pkg::ST_IDLE;
            pend_reg    <= '0;
            rr_reg      <= '0;
            cur_reg     <= '0;
            cnt_reg     <= '0;
            eoc_cnt_reg <= '0;
            sample_o    <= 1'b0;
            hold_o      <= 1'b0;
            slot_o      <= '0;
        end else begin
            pend_reg <= pend_next;
            unique case (state_reg)
                adc_conv_pkg::ST_IDLE: begin
                    if (start_ok) begin
                        cur_reg   <= start_slot;
                        slot_o    <= start_slot;
                        cnt_reg   <= acq_window_count[start_slot];
                        rr_reg    <= SW'((int'(start_slot) + 1) % SLOTS);
                        sample_o  <= 1'b1;
                        hold_o    <= acq_window_count[start_slot] < 9'(HOLD_CYC);
                        state_reg <= adc_conv_pkg::ST_SAMPLE;
                    end
                end
                adc_conv_pkg::ST_SAMPLE: begin
                    if (cnt_reg <= 9'(HOLD_CYC)) begin
                        hold_o <= 1'b1;
                    end
                    if (cnt_reg == 9'h000) begin
                        sample_o    <= 1'b0;
                        eoc_cnt_reg <= eoc_len(converter_clock_divider);
                        state_reg   <= adc_conv_pkg::ST_CONV;
                    end else begin
                        cnt_reg <= cnt_reg - 9'h001;
                    end
                end
                adc_conv_pkg::ST_CONV: begin
                    hold_o <= 1'b0;
                    if (eoc_cnt_reg <= 7'h01) begin
                        state_reg <= adc_conv_pkg::ST_IDLE;
                    end else begin
                        eoc_cnt_reg <= eoc_cnt_reg - 7'h01;
                    end
                end
                default: state_reg <= adc_conv_pkg::ST_IDLE;
            endcase
        end
    end

    // Result latch timing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lat_busy_reg <= 1'b0;
            lat_cnt_reg  <= '0;
            lat_slot_reg <= '0;
        end else if (win_end) begin
            lat_busy_reg <= 1'b1;
            lat_cnt_reg  <= lat_len(converter_clock_divider);
            lat_slot_reg <= cur_reg;
        end else if (lat_busy_reg) begin
            lat_cnt_reg <= lat_cnt_reg - 7'h01;
            if (lat_cnt_reg == 7'h01) begin
                lat_busy_reg <= 1'b0;
            end
        end
    end

    // Early flag timing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            early_reg      <= 1'b0;
            early_cnt_reg  <= '0;
            early_slot_reg <= '0;
        end else if (win_end) begin
            early_reg      <= 1'b1;
            early_cnt_reg  <= `INT_EARLY;
            early_slot_reg <= cur_reg;
        end else begin
            early_reg <= 1'b0;
        end
    end

    // Late flag timing, one end-of-conversion interval after the window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            late_reg      <= 1'b0;
            late_cnt_reg  <= '0;
            late_slot_reg <= '0;
        end else if (win_end) begin
            late_reg      <= 1'b1;
            late_cnt_reg  <= eoc_len(converter_clock_divider);
            late_slot_reg <= cur_reg;
        end else if (late_reg) begin
            late_cnt_reg <= late_cnt_reg - 7'h01;
            if (late_cnt_reg == 7'h01) begin
                late_reg <= 1'b0;
            end
        end
    end

    // Result registers
    for (genvar g = 0; g < SLOTS; g++) begin : g_res
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                conversion_result_n[g] <= 12'h000;
            end else if (lat_fire && lat_slot_reg == SW'(g)) begin
                conversion_result_n[g] <= core_data_i;
            end
        end
    end

    // Flag position and flag select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_late_position <= 1'b0;
            done_flag_select   <= '0;
        end else if (wr && wb_i.adr == `ADDR_CTRL_ONE) begin
            flag_late_position <= wb_i.dat[`BIT_LATE_POS];
            done_flag_select   <= wb_i.dat[`BIT_SEL_LSB +: SW];
        end
    end

    // Converter clock converter_clock_divider
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            converter_clock_divider <= `DIV_RESET;
        end else if (wr && wb_i.adr == `ADDR_CTRL_TWO) begin
            converter_clock_divider <= wb_i.dat[`BIT_DIV_LSB +: 4];
        end
    end

    // Interrupt mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= '0;
        end else if (wr && wb_i.adr == `ADDR_MASK) begin
            mask_reg <= wb_i.dat[1:0];
        end
    end

    // Acquisition counts, one per slot
    for (genvar g = 0; g < SLOTS; g++) begin : g_acq
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                acq_window_count[g] <= `ACQ_RESET;
            end else if (wr && acq_hit(wb_i.adr, g) && wb_i.sel[1]) begin
                acq_window_count[g] <= wb_i.dat[8:0];
            end
        end
    end

    // Done flag source per position bit
    wire logic flag_ev = flag_late_position
                       ? (late_fire && late_slot_reg == done_flag_select)
                       : (early_fire && early_slot_reg == done_flag_select);

    // Sticky status: bit0 done flag, bit1 result latched; set beats read-clear
    always_comb begin
        status_next = status_reg;
        if (rd && wb_i.adr == `ADDR_STATUS) begin
            status_next = 2'b00;
        end
        status_next = status_next | {lat_fire, flag_ev};
    end

    // Status register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= '0;
        end else begin
            status_reg <= status_next;
        end
    end

    // Level interrupt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_reg & mask_reg);
        end
    end

    // Read data selection
    always_comb begin
        rd_data_next = '0;
        case (wb_i.adr)
            `ADDR_CTRL_ONE: rd_data_next = 32'({flag_late_position, 4'h0}) | 32'(done_flag_select);
            `ADDR_CTRL_TWO: rd_data_next = 32'(converter_clock_divider);
            `ADDR_STATUS:   rd_data_next = 32'(status_reg);
            `ADDR_MASK:     rd_data_next = 32'(mask_reg);
            `ADDR_BUSY:     rd_data_next = 32'({pend_reg, lat_busy_reg, state_reg});
            default:        rd_data_next = '0;
        endcase
        for (int i = 0; i < SLOTS; i++) begin
            if (acq_hit(wb_i.adr, i)) begin
                rd_data_next = 32'(acq_window_count[i]);
            end
            if (res_hit(wb_i.adr, i)) begin
                rd_data_next = 32'(conversion_result_n[i]);
            end
        end
    end

    // Bus answer, one cycle after the take edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= rd ? rd_data_next : 32'h0000_0000;
        end
    end
endmodule : adc_conversion_timing

//--- rtl/adc_conv_defs.svh
// Constants for the converter sequencing and timing block
// Operation
// - The sample window of a slot lasts its acquisition count plus one clock cycles.
// - Every slot keeps its own acquisition count, so window lengths can differ.
// - The analog value is frozen 5 ns rounded up to whole clock cycles before the window ends, one cycle at 25 ns.
// - Reading a result before the new one has latched gives the previous result.
// - The next window may start once the end-of-conversion interval has passed.
// - End-of-conversion interval is 11 at converter_clock_divider 0, then 21 rising by 5 to 86 at 15.
// - Result-latch delay follows the table: 13 at converter_clock_divider 0 through 91 at converter_clock_divider 15.
// - Converter_clock_divider n gives a clock ratio of 1 plus n/2, and setting 1 is invalid.
// - Early flag comes 1 cycle after the window, late flag after the interval.
// - With the late-position bit set the flag rises when the end-of-conversion interval ends.
// - With the late-position bit clear the flag rises one cycle after the window ends.
// - Slots on one trigger convert in turn, the first chosen by a round-robin pointer.
// - A select setting picks which slot's conversion end sets the flag.
`ifndef ADC_CONV_DEFS_SVH
`define ADC_CONV_DEFS_SVH
`define ADDR_CTRL_ONE     8'h00
`define ADDR_CTRL_TWO     8'h04
`define ADDR_TRIG         8'h08
`define ADDR_STATUS       8'h0C
`define ADDR_MASK         8'h10
`define ADDR_BUSY         8'h14
`define ADDR_ACQ_BASE     8'h40
`define ADDR_RES_BASE     8'h80
`define BIT_LATE_POS      4
`define BIT_SEL_LSB       0
`define BIT_DIV_LSB       0
`define HOLD_LEAD_NS      5
`define CLK_PERIOD_NS     25
`define ACQ_RESET         9'h000
`define DIV_RESET         4'h0
`define EOC_FIRST         7'h0B
`define EOC_BASE          7'h0B
`define EOC_STEP          7'h05
`define INT_EARLY         7'h01
`endif

//--- rtl/adc_conv_pkg.sv
// Types for the converter sequencing and timing block
package adc_conv_pkg;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONV   = 2'b10
    } seq_state_t;
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;
endpackage : adc_conv_pkg

//--- verif/conv_timing_properties.sv
// Port-level checker for the converter timing block
`timescale 1ns/10ps
`include "adc_conv_defs.svh"
module conv_timing_checker #(
    parameter int SW = 2
) (
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    input wire adc_conv_pkg::wb_req_t wb_i,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  wb_ack_o,
    input wire logic                  sample_o,
    input wire logic                  hold_o,
    input wire logic [SW-1:0]         slot_o,
    input wire logic [11:0]           core_data_i,
    input wire logic                  irq_o
);
    logic [8:0] acq_reg [2**SW];
    logic [1:0] mask_reg;
    logic [9:0] win_reg;
    wire        wr = wb_i.cyc && wb_i.stb && wb_i.we && !wb_ack_o;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acq_reg  <= '{default: '0};
            mask_reg <= 2'h0;
        end else if (wr && wb_i.adr[7:4] == 4'h4 && wb_i.sel[1:0] == 2'h3) begin
            acq_reg[wb_i.adr[SW+1:2]] <= wb_i.dat[8:0];
        end else if (wr && wb_i.adr == `ADDR_MASK && wb_i.sel[0]) begin
            mask_reg <= wb_i.dat[1:0];
        end
    end
    always_ff @(posedge clk_i) begin
        win_reg <= (rst_i || !sample_o) ? 10'h000 : win_reg + 10'h001;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_next: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_window_len: assert property ($fell(sample_o) |->
        win_reg == {1'b0, acq_reg[$past(slot_o)]} + 10'h001)
        else $error("sample window length wrong");
    a_hold_lead: assert property ($rose(hold_o) |-> sample_o ##1 !sample_o)
        else $error("hold not in last window cycle");
    a_hold_over: assert property ($fell(sample_o) |-> hold_o)
        else $error("hold low at window end");
    a_gap_min: assert property ($fell(sample_o) |-> !sample_o [*8])
        else $error("next window started too early");
    a_slot_steady: assert property (sample_o && $past(sample_o) |-> $stable(slot_o))
        else $error("slot changed inside window");
    a_irq_masked: assert property (irq_o |-> $past(mask_reg) != 2'h0)
        else $error("irq high with mask clear");
    a_reset_quiet: assert property ($past(rst_i) |-> !sample_o && !irq_o && !wb_ack_o)
        else $error("output active after reset");
endmodule : conv_timing_checker
bind adc_conversion_timing conv_timing_checker #(.SW(SW)) i_conv_timing_checker (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sample_o(sample_o), .hold_o(hold_o), .slot_o(slot_o), .core_data_i(core_data_i),
    .irq_o(irq_o));

//--- verif/conv_core_model.sv
// Behavioural converter core giving one code per finished window
`timescale 1ns/10ps
module conv_core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        sample_i,
    input  wire logic [1:0]  slot_i,
    output logic      [11:0] data_o
);
    logic       prev_reg;
    logic [1:0] slot_reg;
    logic [9:0] count_reg;
    always_ff @(posedge clk_i) begin
        prev_reg <= sample_i;
        slot_reg <= slot_i;
        if (rst_i) begin
            count_reg <= 10'h000;
            data_o    <= 12'h000;
        end else if (prev_reg && !sample_i) begin
            count_reg <= count_reg + 10'h001;
            data_o    <= {slot_reg, count_reg};
        end
    end
endmodule : conv_core_model

//--- verif/tb_top.sv
// Directed testbench for the converter timing block
`timescale 1ns/10ps
`include "adc_conv_defs.svh"
module tb_top;
    logic                  clk_i = 1'b0;
    logic                  rst_i = 1'b1;
    adc_conv_pkg::wb_req_t wb_i  = '0;
    logic [31:0]           wb_dat_o, q;
    logic                  wb_ack_o, sample_o, hold_o, irq_o, s_q = 1'b0, i_q = 1'b0;
    logic [1:0]            slot_o;
    logic [11:0]           core_data_i;
    int                    fails = 0, compares = 0, cyc_n = 0, d_e;
    int                    wst[$], wend[$], wsl[$], irqs[$];
    always #12.5 clk_i = ~clk_i;
    adc_conversion_timing #(.SLOTS(4), .SW(2)) i_adc_conversion_timing (.clk_i(clk_i),
        .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .sample_o(sample_o), .hold_o(hold_o), .slot_o(slot_o), .core_data_i(core_data_i),
        .irq_o(irq_o));
    conv_core_model i_conv_core_model (.clk_i(clk_i), .rst_i(rst_i), .sample_i(sample_o),
        .slot_i(slot_o), .data_o(core_data_i));
    always @(posedge clk_i) begin
        cyc_n++;
        if (sample_o === 1'b1 && !s_q) begin
            wst.push_back(cyc_n);
            wsl.push_back(slot_o);
        end
        if (sample_o === 1'b0 && s_q)
            wend.push_back(cyc_n);
        if (irq_o === 1'b1 && !i_q)
            irqs.push_back(cyc_n);
        s_q = sample_o;
        i_q = irq_o;
    end
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_i <= '{1'b1, 1'b1, we, a, 4'hF, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        if (n == 20)
            fails++;
        q = wb_dat_o;
        wb_i <= '0;
        @(posedge clk_i);
    endtask : xfer
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] ex);
        xfer(1'b0, a, 32'h0);
        chk(nm, ex, q & m);
    endtask : rd_chk
    task automatic wait_win(input int k);
        int n;
        n = 0;
        while (wend.size() < k && n < 500) begin
            n++;
            @(posedge clk_i);
        end
        if (n == 500)
            fails++;
    endtask : wait_win
    task automatic final_report();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    initial begin
        repeat (4000) @(posedge clk_i);
        fails++;
        final_report();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd_chk("div", `ADDR_CTRL_TWO, 32'hF, 32'h0);
        rd_chk("acq0", `ADDR_ACQ_BASE, 32'h1FF, 32'h0);
        rd_chk("unmapped", 8'h3C, 32'hFFFFFFFF, 32'h0);
        xfer(1'b1, `ADDR_ACQ_BASE, 32'h3);
        xfer(1'b1, `ADDR_ACQ_BASE + 8'h04, 32'h6);
        xfer(1'b1, `ADDR_MASK, 32'h1);
        xfer(1'b1, `ADDR_TRIG, 32'h3);
        wait_win(2);
        repeat (30) @(posedge clk_i);
        chk("win0", 32'h4, wend[0] - wst[0]);
        chk("win1", 32'h7, wend[1] - wst[1]);
        chk("order", 32'h1, wsl[1]);
        rd_chk("res1", `ADDR_RES_BASE + 8'h04, 32'hFFF, 32'h401);
        rd_chk("status", `ADDR_STATUS, 32'h3, 32'h3);
        d_e = irqs[0] - wend[0];
        xfer(1'b1, `ADDR_CTRL_ONE, 32'h10);
        xfer(1'b1, `ADDR_TRIG, 32'h1);
        wait_win(3);
        repeat (30) @(posedge clk_i);
        chk("late0", 32'd10, irqs[1] - wend[2] - d_e);
        rd_chk("clear", `ADDR_STATUS, 32'h1, 32'h1);
        xfer(1'b1, `ADDR_CTRL_TWO, 32'h2);
        xfer(1'b1, `ADDR_TRIG, 32'h3);
        wait_win(5);
        rd_chk("stale", `ADDR_RES_BASE, 32'hFFF, 32'h002);
        repeat (40) @(posedge clk_i);
        rd_chk("res0", `ADDR_RES_BASE, 32'hFFF, 32'h004);
        chk("rr", 32'h0, wsl[4]);
        chk("eoc", 32'd10, (wst[4] - wend[3]) - (wst[1] - wend[0]));
        chk("late2", 32'd20, irqs[2] - wend[4] - d_e);
        rd_chk("clear2", `ADDR_STATUS, 32'h1, 32'h1);
        xfer(1'b1, `ADDR_MASK, 32'h0);
        xfer(1'b1, `ADDR_CTRL_ONE, 32'h1);
        xfer(1'b1, `ADDR_CTRL_TWO, 32'h1);
        xfer(1'b1, `ADDR_TRIG, 32'h1);
        repeat (60) @(posedge clk_i);
        chk("stall", 32'd5, wst.size());
        xfer(1'b1, `ADDR_CTRL_TWO, 32'h0);
        wait_win(6);
        repeat (30) @(posedge clk_i);
        rd_chk("sel", `ADDR_STATUS, 32'h1, 32'h0);
        xfer(1'b1, `ADDR_TRIG, 32'h2);
        wait_win(7);
        repeat (30) @(posedge clk_i);
        chk("masked", 32'h0, {31'h0, irq_o});
        rd_chk("flag", `ADDR_STATUS, 32'h1, 32'h1);
        rd_chk("cleared", `ADDR_STATUS, 32'h1, 32'h0);
        final_report();
    end
endmodule : tb_top
